// *** core/urs_pkg.sv ***
// shared constants for the register map, sleep control and loopback block
package urs_pkg;
	localparam logic [2:0] ADR_DATA   = 3'h0;
	localparam logic [2:0] ADR_IEN    = 3'h1;
	localparam logic [2:0] ADR_ISTQ   = 3'h2;
	localparam logic [2:0] ADR_LCTL   = 3'h3;
	localparam logic [2:0] ADR_MCTL   = 3'h4;
	localparam logic [2:0] ADR_LSTS   = 3'h5;
	localparam logic [2:0] ADR_MSTS   = 3'h6;
	localparam logic [2:0] ADR_SCR    = 3'h7;
	localparam logic [7:0] ENH_KEY    = 8'hbf;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam int         LCTL_DLAB  = 7;
	localparam int         MCTL_LOOP  = 4;
	localparam int         MCTL_RTS   = 1;
	localparam int         IEN_SLEEP  = 4;
	localparam int         EFR_ENH    = 4;
	localparam logic [7:0] IEN_BASE_M = 8'h0f;
	localparam logic [7:0] IEN_ENH_M  = 8'h3f;
	localparam logic [7:0] MCTL_BASE_M = 8'h1b;
	localparam logic [7:0] MCTL_ENH_M = 8'hbf;
	localparam logic [7:0] EFR_M      = 8'h3f;
	localparam logic [7:0] FCR_BASE_M = 8'hcf;
	localparam logic [7:0] ISR_BASE_M = 8'hcf;
	localparam logic [7:0] LSR_DEF    = 8'h60;
	localparam logic [7:0] ISR_NONE   = 8'h01;
	// arbitrary identity values, not tied to any part
	localparam logic [7:0] REV_CODE   = 8'h5a;
	localparam logic [7:0] IDENT_CODE = 8'ha5;
	localparam int         CLK_MHZ    = 40;
	localparam int         PUMP_US    = 45;
	localparam int         PUMP_CYC   = PUMP_US * CLK_MHZ;
	localparam int         FIFO_W     = 8;
	localparam int         FIFO_D     = 8;
	typedef enum logic [2:0] {
		PWR_AWAKE = 3'b001,
		PWR_FULL  = 3'b010,
		PWR_PUMP  = 3'b100
	} urs_pwr_t;
endpackage

// *** core/urs_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module urs_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;
	assign in_ready  = cnt_r < (AW+1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data  = mem_r[rp_r];
	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data;
				wp_r        <= wp_r + 1'b1;
			end
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** core/urs_top.sv ***
// register decode, full sleep control and loopback routing
// Function
// - full sleep needs uart asleep, pump pin high
// - receivers and registers stay live asleep
// - wake on pump pin low or oscillator
// - transmit held off 45 us after wake
// - modem control bit 4 selects loopback
// - loopback keeps other functions normal, but blocks the uart sleep request
// - transmit shifter output feeds receive input
// - loopback holds tx, rts high; ignores rxd and cts pins
// - decode only with chip select low
// - location 0 is data when divisor off
// - divisor bytes at 0 and 1
// - zero divisor reads revision and identity
// - location 1 is interrupt enable
// - location 2 reads status, writes queue control
// - queue control field layout
// - location 3 always line control
// - location 4 modem control fields
// - location 5 read-only line status
// - location 6 modem status deltas, levels
// - location 7 scratch byte
// - key value exposes enhanced registers
// - enhanced bits gated by enhanced enable
// - uart sleep conditions
`timescale 1ns/1ps
module urs_top (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       cs_n,
	input  wire logic       rd_stb,
	input  wire logic       wr_stb,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	input  wire logic [7:0] line_status_in,
	input  wire logic [3:0] modem_lines_in,
	input  wire logic [5:0] irq_source_in,
	input  wire logic       irq_pending_in,
	input  wire logic       pump_autosleep_pin,
	input  wire logic       osc_running_in,
	input  wire logic       rxd_pin,
	input  wire logic       cts_n_pin,
	input  wire logic       shifter_txd,
	input  wire logic       rx_pop_ready,
	output logic      [7:0] rx_pop_data,
	output logic            rx_pop_valid,
	input  wire logic [7:0] rx_push_data,
	input  wire logic       rx_push_valid,
	output logic            rx_push_ready,
	output logic      [7:0] tx_load_data,
	output logic            tx_load_stb,
	output logic            txd_pin,
	output logic            rts_n_pin,
	output logic            rx_serial_in,
	output logic            cts_internal_n,
	output logic            uart_sleep_req,
	output logic            full_sleep,
	output logic            tx_line_ready,
	output logic      [7:0] line_control_q,
	output logic      [7:0] modem_control_q,
	output logic      [7:0] interrupt_enable_q,
	output logic      [7:0] queue_control_q,
	output logic      [7:0] enhanced_features_q,
	output logic     [15:0] baud_divisor_q,
	output logic     [31:0] flow_chars_q
);
	logic [7:0] lctl_r, mctl_r, ien_r, fcr_r, efr_r, dll_r, dlm_r, scr_r;
	logic [7:0] resume_char_first_r, resume_char_second_r, pause_char_first_r, pause_char_second_r, rd_r;
	logic [7:0] mline_r, rdq_nxt;
	logic [1:0] acp_s_r, osc_s_r, rxd_s_r, cts_s_r;
	logic [3:0] ml_s0_r, ml_s1_r, ml_prev_r, mdelta_r;
	logic       txd_r, rts_r, rxi_r, ctsi_r, usleep_r, tx_stb_r;
	logic       rd_d_r, msr_d_r;
	logic [2:0] ml_arm_r;
	logic [11:0] pump_cnt_r;
	urs_pkg::urs_pwr_t pwr_r, pwr_nxt;
	logic [7:0] rxf_data;
	logic       rxf_valid;

	// chip select qualifies both strobes
	// select qualification
	wire acc_rd = !cs_n && rd_stb;
	wire acc_wr = !cs_n && wr_stb;
	wire dlab   = lctl_r[urs_pkg::LCTL_DLAB];
	wire enh_k  = lctl_r == urs_pkg::ENH_KEY;
	wire enh_on = efr_r[urs_pkg::EFR_ENH];
	wire div_z  = dll_r == urs_pkg::ZERO_BYTE && dlm_r == urs_pkg::ZERO_BYTE;
	wire loop   = mctl_r[urs_pkg::MCTL_LOOP];
	wire [7:0] ien_m  = enh_on ? urs_pkg::IEN_ENH_M : urs_pkg::IEN_BASE_M;
	wire [7:0] mctl_m = enh_on ? urs_pkg::MCTL_ENH_M : urs_pkg::MCTL_BASE_M;
	wire [7:0] fcr_m  = enh_on ? urs_pkg::EFR_M | urs_pkg::FCR_BASE_M : urs_pkg::FCR_BASE_M;
	wire [7:0] isr_m  = enh_on ? urs_pkg::EFR_M | urs_pkg::ISR_BASE_M : urs_pkg::ISR_BASE_M;
	wire [7:0] isr_v  = {{2{fcr_r[0]}}, 6'(irq_source_in)} & isr_m;

	// write decodes
	// data on location zero
	wire w_thr  = acc_wr && addr == urs_pkg::ADR_DATA && !dlab;
	wire w_dll  = acc_wr && addr == urs_pkg::ADR_DATA && dlab;
	wire w_dlm  = acc_wr && addr == urs_pkg::ADR_IEN && dlab;
	wire w_ien  = acc_wr && addr == urs_pkg::ADR_IEN && !dlab;
	wire w_fcr  = acc_wr && addr == urs_pkg::ADR_ISTQ && !enh_k;
	wire w_efr  = acc_wr && addr == urs_pkg::ADR_ISTQ && enh_k;
	wire w_x1   = acc_wr && addr == urs_pkg::ADR_MCTL && enh_k;
	wire w_x2   = acc_wr && addr == urs_pkg::ADR_LSTS && enh_k;
	wire w_f1   = acc_wr && addr == urs_pkg::ADR_MSTS && enh_k;
	wire w_f2   = acc_wr && addr == urs_pkg::ADR_SCR && enh_k;
	wire w_lctl = acc_wr && addr == urs_pkg::ADR_LCTL;
	wire w_mctl = acc_wr && addr == urs_pkg::ADR_MCTL && !enh_k;
	wire w_scr  = acc_wr && addr == urs_pkg::ADR_SCR && !enh_k;
	wire r_rhr  = acc_rd && addr == urs_pkg::ADR_DATA && !dlab;
	wire r_msr  = acc_rd && addr == urs_pkg::ADR_MSTS;

	// read mux; rd_data reloads on every read access cycle, pops and clears act on its rising edge only
	always_comb begin
		rdq_nxt = urs_pkg::ZERO_BYTE;
		if (addr == urs_pkg::ADR_DATA) begin
			if (dlab)
				rdq_nxt = div_z ? urs_pkg::REV_CODE : dll_r;
			else
				rdq_nxt = rxf_valid ? rxf_data : urs_pkg::ZERO_BYTE;
		end else if (addr == urs_pkg::ADR_IEN) begin
			if (dlab)
				rdq_nxt = div_z ? urs_pkg::IDENT_CODE : dlm_r;
			else
				rdq_nxt = ien_r & ien_m;
		end else if (addr == urs_pkg::ADR_ISTQ) begin
			rdq_nxt = enh_k ? efr_r : isr_v;
		end else if (addr == urs_pkg::ADR_LCTL) begin
			rdq_nxt = lctl_r;
		end else if (addr == urs_pkg::ADR_MCTL) begin
			rdq_nxt = enh_k ? urs_pkg::ZERO_BYTE : mctl_r & mctl_m;
		end else if (addr == urs_pkg::ADR_LSTS) begin
			rdq_nxt = line_status_in;
		end else if (addr == urs_pkg::ADR_MSTS) begin
			rdq_nxt = {ml_prev_r, mdelta_r};
		end else begin
			rdq_nxt = enh_k ? urs_pkg::ZERO_BYTE : scr_r;
		end
	end

	// receive data buffered between shifter and host
	urs_fifo #(
		.W(urs_pkg::FIFO_W),
		.D(urs_pkg::FIFO_D)
	) u_rxq (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.flush     (w_fcr && wr_data[1]),
		.in_data   (rx_push_data),
		.in_valid  (rx_push_valid),
		.in_ready  (rx_push_ready),
		.out_data  (rxf_data),
		.out_valid (rxf_valid),
		.out_ready (rx_pop_ready || (r_rhr && !rd_d_r))
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lctl_r <= urs_pkg::ZERO_BYTE;
			mctl_r <= urs_pkg::ZERO_BYTE;
			ien_r  <= urs_pkg::ZERO_BYTE;
			fcr_r  <= urs_pkg::ZERO_BYTE;
			efr_r  <= urs_pkg::ZERO_BYTE;
			dll_r  <= urs_pkg::ZERO_BYTE;
			dlm_r  <= urs_pkg::ZERO_BYTE;
			scr_r  <= urs_pkg::ZERO_BYTE;
			resume_char_first_r <= urs_pkg::ZERO_BYTE;
			resume_char_second_r <= urs_pkg::ZERO_BYTE;
			pause_char_first_r <= urs_pkg::ZERO_BYTE;
			pause_char_second_r <= urs_pkg::ZERO_BYTE;
		end else begin
			if (w_lctl) lctl_r <= wr_data;
			if (w_mctl) mctl_r <= wr_data & mctl_m;
			if (w_ien)  ien_r <= wr_data & ien_m;
			if (w_fcr)  fcr_r <= wr_data & fcr_m & 8'hf9;
			if (w_efr)  efr_r <= wr_data & urs_pkg::EFR_M;
			if (w_dll)  dll_r <= wr_data;
			if (w_dlm)  dlm_r <= wr_data;
			if (w_scr)  scr_r <= wr_data;
			if (w_x1)   resume_char_first_r <= wr_data;
			if (w_x2)   resume_char_second_r <= wr_data;
			if (w_f1)   pause_char_first_r <= wr_data;
			if (w_f2)   pause_char_second_r <= wr_data;
		end
	end

	// read data and pulse outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_r     <= urs_pkg::ZERO_BYTE;
			rd_d_r   <= 1'b0;
			tx_stb_r <= 1'b0;
			mline_r  <= urs_pkg::ZERO_BYTE;
		end else begin
			rd_d_r   <= r_rhr;
			tx_stb_r <= w_thr;
			if (acc_rd) rd_r <= rdq_nxt;
			if (w_thr)  mline_r <= wr_data;
		end
	end

	// pin synchronisers, two stages before use
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acp_s_r <= 2'h0;
			osc_s_r <= 2'h0;
			rxd_s_r <= 2'h0;
			cts_s_r <= 2'h3;
			ml_s0_r <= 4'h0;
			ml_s1_r <= 4'h0;
		end else begin
			acp_s_r <= {acp_s_r[0], pump_autosleep_pin};
			osc_s_r <= {osc_s_r[0], osc_running_in};
			rxd_s_r <= {rxd_s_r[0], rxd_pin};
			cts_s_r <= {cts_s_r[0], cts_n_pin};
			ml_s0_r <= modem_lines_in;
			ml_s1_r <= ml_s0_r;
		end
	end

	// modem deltas: a change on the read cycle survives the clear
	// held off until the sync stages carry real levels, else reset fakes a change
	wire [3:0] mchg = (ml_s1_r ^ ml_prev_r) & {4{ml_arm_r[2]}};
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ml_prev_r <= 4'h0;
			mdelta_r  <= 4'h0;
			ml_arm_r  <= 3'h0;
			msr_d_r   <= 1'b0;
		end else begin
			ml_prev_r <= ml_s1_r;
			ml_arm_r  <= {ml_arm_r[1:0], 1'b1};
			// a held status read clears only once
			msr_d_r   <= r_msr;
			mdelta_r  <= (r_msr && !msr_d_r ? 4'h0 : mdelta_r) | mchg;
		end
	end

	wire us_nxt = !irq_pending_in && !div_z && ien_r[urs_pkg::IEN_SLEEP] && enh_on
		&& !rxd_s_r[1] && !loop;

	// power state; registers stay reachable in every state
	// bus untouched by sleep
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			urs_pkg::PWR_AWAKE: begin
				if (usleep_r && !osc_s_r[1] && acp_s_r[1])
					pwr_nxt = urs_pkg::PWR_FULL;
			end
			urs_pkg::PWR_FULL: begin
				if (!acp_s_r[1] || osc_s_r[1])
					pwr_nxt = urs_pkg::PWR_PUMP;
			end
			urs_pkg::PWR_PUMP: begin
				if (pump_cnt_r == 12'(urs_pkg::PUMP_CYC - 1))
					pwr_nxt = urs_pkg::PWR_AWAKE;
			end
			default: pwr_nxt = urs_pkg::PWR_AWAKE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_r      <= urs_pkg::PWR_AWAKE;
			pump_cnt_r <= 12'h000;
			usleep_r   <= 1'b0;
		end else begin
			pwr_r    <= pwr_nxt;
			usleep_r <= us_nxt;
			if (pwr_r == urs_pkg::PWR_PUMP)
				pump_cnt_r <= pump_cnt_r + 12'h001;
			else
				pump_cnt_r <= 12'h000;
		end
	end

	// line routing; flow control logic outside is untouched by loopback
	// only pins rerouted
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			txd_r  <= 1'b1;
			rts_r  <= 1'b1;
			rxi_r  <= 1'b1;
			ctsi_r <= 1'b1;
		end else begin
			if (loop) begin
				txd_r  <= 1'b1;
				rts_r  <= 1'b1;
				rxi_r  <= shifter_txd;
				ctsi_r <= !mctl_r[urs_pkg::MCTL_RTS];
			end else begin
				txd_r  <= pwr_r == urs_pkg::PWR_AWAKE ? shifter_txd : 1'b1;
				rts_r  <= !mctl_r[urs_pkg::MCTL_RTS];
				rxi_r  <= rxd_s_r[1];
				ctsi_r <= cts_s_r[1];
			end
		end
	end

	assign rd_data             = rd_r;
	assign rx_pop_data         = rxf_data;
	assign rx_pop_valid        = rxf_valid;
	assign tx_load_data        = mline_r;
	assign tx_load_stb         = tx_stb_r;
	assign txd_pin             = txd_r;
	assign rts_n_pin           = rts_r;
	assign rx_serial_in        = rxi_r;
	assign cts_internal_n      = ctsi_r;
	assign uart_sleep_req      = usleep_r;
	assign full_sleep          = pwr_r == urs_pkg::PWR_FULL;
	assign tx_line_ready       = pwr_r == urs_pkg::PWR_AWAKE;
	assign line_control_q      = lctl_r;
	assign modem_control_q     = mctl_r;
	assign interrupt_enable_q  = ien_r;
	assign queue_control_q     = fcr_r;
	assign enhanced_features_q = efr_r;
	assign baud_divisor_q      = {dlm_r, dll_r};
	assign flow_chars_q        = {pause_char_second_r, pause_char_first_r, resume_char_second_r, resume_char_first_r};
endmodule

// *** tb/urs_host.sv ***
// host model driving the parallel register port
`timescale 1ns/1ps
module urs_host (
	input  wire logic       core_clk,
	output logic            cs_n,
	output logic            rd_stb,
	output logic            wr_stb,
	output logic      [2:0] addr,
	output logic      [7:0] wr_data,
	input  wire logic [7:0] rd_data
);
	initial begin
		cs_n = 1'b1;
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		addr = 3'h0;
		wr_data = 8'h00;
	end
	task automatic xfer(input logic w, input logic c, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		cs_n <= c;
		rd_stb <= !w;
		wr_stb <= w;
		addr <= a;
		wr_data <= d;
		@(posedge core_clk);
		cs_n <= 1'b1;
		rd_stb <= 1'b0;
		wr_stb <= 1'b0;
		// released data lines must not keep the last byte
		wr_data <= ~d;
		#1 q = rd_data;
	endtask
endmodule

// *** tb/urs_top_asserts.sv ***
// concurrent checks on decode, sleep and loopback ports
`timescale 1ns/1ps
module urs_top_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        cs_n,
	input wire logic        wr_stb,
	input wire logic [2:0]  addr,
	input wire logic [7:0]  wr_data,
	input wire logic [7:0]  rd_data,
	input wire logic        shifter_txd,
	input wire logic        pump_autosleep_pin,
	input wire logic        txd_pin,
	input wire logic        rts_n_pin,
	input wire logic        rx_serial_in,
	input wire logic        uart_sleep_req,
	input wire logic        full_sleep,
	input wire logic        tx_line_ready,
	input wire logic [7:0]  line_control_q,
	input wire logic [7:0]  modem_control_q,
	input wire logic [7:0]  interrupt_enable_q,
	input wire logic [15:0] baud_divisor_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [11:0] wait_r;
	// cycles of pump recovery since leaving full sleep
	always_ff @(posedge core_clk) begin
		if (!rst_n || tx_line_ready || full_sleep)
			wait_r <= 12'h000;
		else
			wait_r <= wait_r + 12'h001;
	end
	sequence s_loop;
		modem_control_q[urs_pkg::MCTL_LOOP] [*2];
	endsequence
	sequence s_wake;
		full_sleep ##1 !full_sleep;
	endsequence
	lctl_write_a:
	assert property (!cs_n && wr_stb && addr == 3'h3 |=> line_control_q == $past(wr_data))
		else $error("line control write lost");
	cs_gate_a:
	assert property (cs_n |=> $stable({rd_data, line_control_q, modem_control_q,
		interrupt_enable_q, baud_divisor_q})) else $error("access without chip select");
	loop_pins_a:
	assert property (s_loop |-> txd_pin && rts_n_pin) else $error("loopback pins not high");
	loop_route_a:
	assert property (s_loop |-> rx_serial_in == $past(shifter_txd))
		else $error("loopback route broken");
	sleep_entry_a:
	assert property ($rose(full_sleep) |-> $past(uart_sleep_req) && $past(pump_autosleep_pin, 3))
		else $error("full sleep without cause");
	sleep_exit_a:
	assert property (full_sleep && !pump_autosleep_pin |-> ##[1:4] !full_sleep)
		else $error("full sleep not left");
	pump_hold_a:
	assert property (s_wake |-> !tx_line_ready) else $error("line ready at wake");
	pump_time_a:
	assert property ($rose(tx_line_ready) |-> wait_r == urs_pkg::PUMP_CYC)
		else $error("pump recovery length wrong");
	txd_idle_a:
	assert property ((!tx_line_ready && !full_sleep) [*2] |-> txd_pin)
		else $error("txd driven during recovery");
	sleep_cond_a:
	assert property ((!interrupt_enable_q[urs_pkg::IEN_SLEEP] || baud_divisor_q == 16'h0000)
		[*2] |-> !uart_sleep_req) else $error("sleep request unqualified");
endmodule
bind urs_top urs_top_chk u_chk (.core_clk, .rst_n, .cs_n, .wr_stb, .addr, .wr_data,
	.rd_data, .shifter_txd, .pump_autosleep_pin, .txd_pin, .rts_n_pin, .rx_serial_in,
	.uart_sleep_req, .full_sleep, .tx_line_ready, .line_control_q, .modem_control_q,
	.interrupt_enable_q, .baud_divisor_q);

// *** tb/tb.sv ***
// self-checking bench for register map, sleep and loopback
`timescale 1ns/1ps
module tb;
	logic        core_clk, rst_n, cs_n, rd_stb, wr_stb, irq_pending_in, pump_autosleep_pin;
	logic        osc_running_in, rxd_pin, cts_n_pin, shifter_txd, rx_pop_ready, rx_pop_valid;
	logic        rx_push_valid, rx_push_ready, tx_load_stb, txd_pin, rts_n_pin, rx_serial_in;
	logic        cts_internal_n, uart_sleep_req, full_sleep, tx_line_ready;
	logic [2:0]  addr;
	logic [3:0]  modem_lines_in;
	logic [5:0]  irq_source_in;
	logic [7:0]  wr_data, rd_data, line_status_in, rx_pop_data, rx_push_data, tx_load_data, q;
	logic [7:0]  line_control_q, modem_control_q, interrupt_enable_q, queue_control_q;
	logic [7:0]  enhanced_features_q;
	logic [15:0] baud_divisor_q;
	logic [31:0] flow_chars_q;
	int          n_errors, checks_done, cyc;
	urs_top DUT (.core_clk, .rst_n, .cs_n, .rd_stb, .wr_stb, .addr, .wr_data, .rd_data,
		.line_status_in, .modem_lines_in, .irq_source_in, .irq_pending_in,
		.pump_autosleep_pin, .osc_running_in, .rxd_pin, .cts_n_pin, .shifter_txd,
		.rx_pop_ready, .rx_pop_data, .rx_pop_valid, .rx_push_data, .rx_push_valid,
		.rx_push_ready, .tx_load_data, .tx_load_stb, .txd_pin, .rts_n_pin, .rx_serial_in,
		.cts_internal_n, .uart_sleep_req, .full_sleep, .tx_line_ready, .line_control_q,
		.modem_control_q, .interrupt_enable_q, .queue_control_q, .enhanced_features_q,
		.baud_divisor_q, .flow_chars_q);
	urs_host host (.core_clk, .cs_n, .rd_stb, .wr_stb, .addr, .wr_data, .rd_data);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.xfer(1'b1, 1'b0, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		host.xfer(1'b0, 1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic t_regs;
		chk({line_control_q, modem_control_q, interrupt_enable_q, baud_divisor_q[7:0]}, 0);
		wr(3'h3, 8'h1b);
		rd(3'h3, 8'h1b);
		wr(3'h7, 8'h5c);
		host.xfer(1'b1, 1'b1, 3'h7, 8'h33, q);
		rd(3'h7, 8'h5c);
		wr(3'h1, 8'hff);
		rd(3'h1, 8'h0f);
		wr(3'h3, 8'h80);
		rd(3'h0, urs_pkg::REV_CODE);
		rd(3'h1, urs_pkg::IDENT_CODE);
		wr(3'h0, 8'h12);
		wr(3'h1, 8'h34);
		rd(3'h0, 8'h12);
		rd(3'h1, 8'h34);
		chk(baud_divisor_q, 16'h3412);
		rd(3'h5, 8'h61);
		host.xfer(1'b0, 1'b0, 3'h6, 8'h00, q);
		chk(q, 8'ha0);
		modem_lines_in <= 4'hb;
		repeat (4) @(posedge core_clk);
		host.xfer(1'b0, 1'b0, 3'h6, 8'h00, q);
		chk(q, 8'hb1);
		wr(3'h3, 8'h03);
		wr(3'h2, 8'hff);
		chk(queue_control_q, 8'hc9);
		rd(3'h2, 8'hcc);
		wr(3'h3, 8'hbf);
		wr(3'h2, 8'h1f);
		rd(3'h2, 8'h1f);
		chk(enhanced_features_q, 8'h1f);
		wr(3'h4, 8'h11);
		wr(3'h5, 8'h22);
		wr(3'h6, 8'h33);
		wr(3'h7, 8'h44);
		chk(flow_chars_q, 32'h44332211);
		wr(3'h3, 8'h03);
		wr(3'h1, 8'hff);
		rd(3'h1, 8'h3f);
		rd(3'h7, 8'h5c);
	endtask
	task automatic t_data;
		int n;
		logic ok;
		wr(3'h0, 8'h96);
		chk({tx_load_stb, tx_load_data}, 9'h196);
		@(posedge core_clk);
		rx_push_data <= 8'h40;
		rx_push_valid <= 1'b1;
		n = 0;
		for (int i = 0; i < 12; i++) begin
			#1 ok = rx_push_ready;
			@(posedge core_clk);
			n = ok ? n + 1 : n;
			rx_push_data <= 8'h40 + 8'(n);
		end
		rx_push_valid <= 1'b0;
		chk({n[7:0], tx_load_stb}, 9'h010);
		for (int i = 0; i < 4; i++)
			rd(3'h0, 8'h40 + 8'(i));
		@(posedge core_clk);
		rx_pop_ready <= 1'b1;
		for (int i = 4; i < 8; i++) begin
			#1 chk({rx_pop_valid, rx_pop_data}, {1'b1, 8'h40 + 8'(i)});
			@(posedge core_clk);
		end
		rx_pop_ready <= 1'b0;
		#1 chk(rx_pop_valid, 1'b0);
	endtask
	task automatic t_loop;
		wr(3'h4, 8'h02);
		@(posedge core_clk);
		#1 chk(rts_n_pin, 1'b0);
		wr(3'h4, 8'h12);
		repeat (2) @(posedge core_clk);
		#1 chk({modem_control_q, txd_pin, rts_n_pin, cts_internal_n}, 11'h096);
		rd(3'h7, 8'h5c);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			shifter_txd <= i[0];
			@(posedge core_clk);
			#1 chk({rx_serial_in, txd_pin}, {i[0], 1'b1});
		end
		wr(3'h4, 8'h00);
		repeat (3) @(posedge core_clk);
		#1 chk({rx_serial_in, cts_internal_n}, 2'b01);
	endtask
	task automatic wake_check;
		int n;
		for (n = 0; n < 10 && full_sleep === 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk({full_sleep, tx_line_ready, txd_pin}, 3'b001);
		for (n = 0; n < 3000 && tx_line_ready !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk(n > urs_pkg::PUMP_CYC - 8 && n <= urs_pkg::PUMP_CYC, 1'b1);
	endtask
	task automatic t_sleep;
		chk(uart_sleep_req, 1'b0);
		irq_pending_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1 chk(uart_sleep_req, 1'b1);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			pump_autosleep_pin <= 1'b1;
			osc_running_in <= 1'b0;
			repeat (6) @(posedge core_clk);
			#1 chk(full_sleep, 1'b1);
			wr(3'h7, 8'h70 + 8'(k));
			rd(3'h7, 8'h70 + 8'(k));
			@(posedge core_clk);
			if (k == 0)
				pump_autosleep_pin <= 1'b0;
			else
				osc_running_in <= 1'b1;
			wake_check();
		end
	endtask
	initial begin
		n_errors = 0;
		checks_done = 0;
		cyc = 0;
		rst_n = 1'b0;
		line_status_in = 8'h61;
		modem_lines_in = 4'ha;
		irq_source_in = 6'h3c;
		irq_pending_in = 1'b1;
		pump_autosleep_pin = 1'b0;
		osc_running_in = 1'b1;
		rxd_pin = 1'b0; // idle low
		cts_n_pin = 1'b1;
		shifter_txd = 1'b1;
		rx_pop_ready = 1'b0;
		rx_push_data = 8'h00;
		rx_push_valid = 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_data();
		t_loop();
		t_sleep();
		close_out();
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
endmodule
